//--- clb_bus_ctrl.v
// Functional notes
// [R1] latch strobe high for the first T-state of each bus cycle
// [R2] latch strobe pin is always driven, never floated
// [R3] write strobe low in T2, T3 and waits of writes; floats in hold
// [R4] write strobe driven high one clock in reset, then undriven
// [R5] queue-state pins report 00 nop, 01 first, 11 next, 10 empty
// [R6] read pin sampled in reset; low selects queue-status outputs
// [R7] read strobe low in T2, T3, waits of reads; address off; floats in hold
// [R8] only the rising edge of async ready is synchronised
// [R9] cycle ends only on a ready input; else wait states
// [R10] sync ready is synchronised outside and tied low if unused
// [R11] lock low from first data cycle after prefix; high one reset clock
// [R12] no prefetch cycles while lock is asserted
// [R13] cycle status encoding of the eight bus cycle kinds
// [R14] hold answered with grant after T4 or idle, bus floats at once
// [R15] grant drops after hold low; bus driven again at next cycle
// [R16] upper memory select for programmed top block, never floated
// [R17] lower memory select for programmed bottom block, never floated
// [R18] four mid-range selects for programmed mid region, never floated
// [R19] peripheral selects for programmed io ranges, never floated
// [R20] selects 5 and 6 may output latched a1/a2, kept in hold
// [R21] transceiver direction low on reads, high on writes
// [R22] transceiver enable low in accesses, high while direction changes
// [R23] cycles run t1, t2, t3, waits, then t4
`timescale 1ns/10ps
`default_nettype none
`include "clb_map.vh"
module clb_bus_ctrl (
	input  wire        i_clk_sys,
	input  wire        i_rst_n,
	input  wire [2:0]  i_reg_addr,
	input  wire [15:0] i_reg_wdata,
	input  wire        i_reg_wr,
	input  wire        i_reg_rd,
	output reg  [15:0] o_reg_rdata,
	input  wire        i_cyc_req,
	input  wire [2:0]  i_cyc_kind,
	input  wire [19:0] i_cyc_addr,
	input  wire [15:0] i_cyc_wdata,
	input  wire        i_lock_req,
	input  wire [1:0]  i_queue_op,
	output wire        o_cyc_ready,
	output reg         o_cyc_done,
	output reg  [15:0] o_cyc_rdata,
	output wire        o_ale_or_queue_state_lo,
	output wire        o_wr_n_or_queue_state_hi,
	output wire        o_wr_oe,
	output wire        o_rd_n,
	output wire        o_rd_oe,
	input  wire        i_rd_in,
	output reg  [15:0] o_ad,
	output reg         o_ad_oe,
	input  wire [15:0] i_ad,
	output reg  [3:0]  o_addr_hi,
	output wire        o_addr_hi_oe,
	input  wire        i_async_ready_in,
	input  wire        i_sync_ready_in,
	output wire        o_lock_n,
	output wire        o_lock_oe,
	output wire [2:0]  o_cycle_status,
	output wire        o_cycle_status_oe,
	input  wire        i_hold_req,
	output reg         o_hold_grant,
	output reg         o_upper_mem_select_n,
	output reg         o_lower_mem_select_n,
	output reg  [3:0]  o_mid_mem_select_n,
	output reg  [4:0]  o_periph_select_n,
	output wire        o_periph_select5_or_addr1,
	output wire        o_periph_select6_or_addr2,
	output reg         o_xcvr_direction,
	output wire        o_xcvr_direction_oe,
	output reg         o_xcvr_enable_n,
	output wire        o_xcvr_enable_oe
);
	// ****************************************
	// states
	// ****************************************
	localparam [6:0] S_IDLE = 7'h01;
	localparam [6:0] S_T1   = 7'h02;
	localparam [6:0] S_T2   = 7'h04;
	localparam [6:0] S_T3   = 7'h08;
	localparam [6:0] S_TW   = 7'h10;
	localparam [6:0] S_T4   = 7'h20;
	localparam [6:0] S_HOLD = 7'h40;

	// ****************************************
	// decode helpers
	// ****************************************
	function is_wr;
		input [2:0] k;
		is_wr = (k == `CLB_ST_IOWR) || (k == `CLB_ST_MEMWR);
	endfunction
	function is_rd;
		input [2:0] k;
		is_rd = (k == `CLB_ST_IORD) || (k == `CLB_ST_FETCH) || (k == `CLB_ST_MEMRD);
	endfunction
	function is_mem;
		input [2:0] k;
		is_mem = k[2] & ~(k[1] & k[0]);
	endfunction
	function is_io;
		input [2:0] k;
		is_io = (k == `CLB_ST_IORD) || (k == `CLB_ST_IOWR);
	endfunction
	// mask of 1k address bits that must match for a block of 1k << n
	function [9:0] kb_mask;
		input [3:0] n;
		reg   [3:0] c;
		begin
			c = (n > `CLB_KB_MAX_CODE) ? `CLB_KB_MAX_CODE : n;
			kb_mask = 10'h3ff << c;
		end
	endfunction

	// ****************************************
	// state and registers
	// ****************************************
	reg  [6:0]  st_r;
	reg  [6:0]  st_nxt;
	reg  [2:0]  kind_r;
	reg  [19:0] addr_r;
	reg  [15:0] wdata_r;
	reg  [3:0]  ucs_size_r;
	reg  [3:0]  lcs_size_r;
	reg  [6:0]  mcs_base_r;
	reg  [2:0]  mcs_size_r;
	reg  [5:0]  pcs_base_r;
	reg  [3:0]  mode_r;
	reg         qmode_r;
	reg         rst_seen_r;
	reg         own_r;
	reg         ale_r;
	reg         wr_n_r;
	reg         rd_n_r;
	reg         lock_r;
	reg  [2:0]  status_r;
	reg  [1:0]  queue_r;
	reg         hold_s1_r;
	reg         hold_s2_r;
	reg         async_ready_in_s1_r;
	reg         async_ready_in_s2_r;
	reg  [2:1]  lat_a_r;
	reg  [6:5]  pcs_hi_n_r;
	reg  [15:0] reg_val;

	// one clock of high drive at the first reset edge, then float
	wire drive_pulse = ~i_rst_n & ~rst_seen_r; // [R4] [R11]
	// a falling async_ready_in acts at once; the raw pin may only cut a synchronised high
	wire async_ready_in_eff = async_ready_in_s2_r & i_async_ready_in; // [R8]
	wire ready = async_ready_in_eff | i_sync_ready_in; // [R9] [R10]
	wire hold_take = hold_s2_r & ~lock_r;
	wire at_edge = (st_r == S_IDLE) || (st_r == S_T4);
	assign o_cyc_ready = i_rst_n & at_edge & ~hold_take &
		~(lock_r & (i_cyc_kind == `CLB_ST_FETCH)); // [R12]
	wire accept = i_cyc_req & o_cyc_ready;

	// ****************************************
	// chip select decode of the request
	// ****************************************
	wire [9:0]  um = kb_mask(ucs_size_r);
	wire [9:0]  lm = kb_mask(lcs_size_r);
	wire [2:0]  msc = (mcs_size_r > `CLB_MID_MAX_CODE) ? `CLB_MID_MAX_CODE : mcs_size_r;
	wire [6:0]  mm = 7'h7f << msc;
	wire [19:0] mshift = i_cyc_addr >> ({2'h0, msc} + `CLB_MID_QSHIFT);
	wire        c_mem = is_mem(i_cyc_kind);
	wire        c_io = is_io(i_cyc_kind);
	wire        ucs_hit = c_mem & ((i_cyc_addr[19:10] & um) == um); // [R16]
	wire        lcs_hit = mode_r[`CLB_MODE_LCS_EN] & c_mem &
		((i_cyc_addr[19:10] & lm) == 10'h000); // [R17]
	wire        mcs_hit = mode_r[`CLB_MODE_MCS_EN] & c_mem &
		((i_cyc_addr[19:13] & mm) == (mcs_base_r & mm)); // [R18]
	wire        pcs_hit = mode_r[`CLB_MODE_PCS_EN] & c_io &
		(i_cyc_addr[15:10] == pcs_base_r); // [R19]
	wire [3:0]  mcs_vec;
	wire [6:0]  pcs_vec;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi = gi + 1) begin : g_mcs
			assign mcs_vec[gi] = mcs_hit & (mshift[1:0] == gi); // [R18]
		end
		for (gi = 0; gi < 7; gi = gi + 1) begin : g_pcs
			assign pcs_vec[gi] = pcs_hit & (i_cyc_addr[9:7] == gi); // [R19]
		end
	endgenerate

	// ****************************************
	// bus cycle sequencer
	// ****************************************
	// hold has priority over a new cycle at each cycle boundary while lock is not held
	always @* begin
		st_nxt = st_r;
		case (st_r)
			S_IDLE, S_T4: begin
				if (hold_take) begin
					st_nxt = S_HOLD; // [R14]
				end else if (accept) begin
					st_nxt = S_T1; // [R23]
				end else begin
					st_nxt = S_IDLE;
				end
			end
			S_T1: st_nxt = S_T2; // [R23]
			S_T2: st_nxt = S_T3; // [R23]
			S_T3, S_TW: begin
				st_nxt = ready ? S_T4 : S_TW; // [R9] [R23]
			end
			S_HOLD: begin
				st_nxt = hold_s2_r ? S_HOLD : S_IDLE; // [R15]
			end
			default: st_nxt = S_IDLE;
		endcase
	end

	wire nx_data = (st_nxt == S_T2) || (st_nxt == S_T3) || (st_nxt == S_TW);
	wire has_data = (kind_r != `CLB_ST_HALT) && (kind_r != `CLB_ST_PASV);

	// ****************************************
	// synchronisers
	// ****************************************
	// hold is asynchronous; async_ready_in's first stage feeds only its second stage
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			hold_s1_r <= 1'b0;
			hold_s2_r <= 1'b0;
			async_ready_in_s1_r <= 1'b0;
			async_ready_in_s2_r <= 1'b0;
		end else begin
			hold_s1_r <= i_hold_req;
			hold_s2_r <= hold_s1_r;
			async_ready_in_s1_r <= i_async_ready_in; // [R8]
			async_ready_in_s2_r <= async_ready_in_s1_r;
		end
	end

	// strap is caught from the second reset clock, after the high drive ends
	always @(posedge i_clk_sys) begin
		if (!i_rst_n && rst_seen_r) begin
			qmode_r <= ~i_rd_in; // [R6]
		end
	end

	// ****************************************
	// cycle state, strobes and data
	// ****************************************
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			st_r <= S_IDLE;
			rst_seen_r <= 1'b1;
			own_r <= 1'b0;
			kind_r <= `CLB_ST_PASV;
			addr_r <= 20'h00000;
			wdata_r <= 16'h0000;
			ale_r <= 1'b0;
			wr_n_r <= 1'b1;
			rd_n_r <= 1'b1;
			lock_r <= 1'b0;
			status_r <= `CLB_ST_PASV;
			queue_r <= `CLB_Q_NOP;
			o_hold_grant <= 1'b0;
			o_cyc_done <= 1'b0;
			o_cyc_rdata <= 16'h0000;
			o_ad <= 16'h0000;
			o_ad_oe <= 1'b0;
			o_addr_hi <= 4'h0;
			o_xcvr_direction <= 1'b0;
			o_xcvr_enable_n <= 1'b1;
			o_upper_mem_select_n <= 1'b1;
			o_lower_mem_select_n <= 1'b1;
			o_mid_mem_select_n <= 4'hf;
			o_periph_select_n <= 5'h1f;
			pcs_hi_n_r <= 2'h3;
			lat_a_r <= 2'h0;
		end else begin
			st_r <= st_nxt;
			rst_seen_r <= 1'b0;
			queue_r <= i_queue_op; // [R5]
			o_cyc_done <= 1'b0;
			// latch strobe only in t1; pin stays driven in hold
			ale_r <= (st_nxt == S_T1); // [R1] [R2]
			if (accept) begin
				kind_r <= i_cyc_kind;
				addr_r <= i_cyc_addr;
				wdata_r <= i_cyc_wdata;
				own_r <= 1'b1; // [R15]
				status_r <= i_cyc_kind; // [R13]
				o_ad <= i_cyc_addr[15:0];
				o_ad_oe <= 1'b1;
				o_addr_hi <= i_cyc_addr[19:16];
				lat_a_r <= i_cyc_addr[2:1]; // [R20]
				// direction moves only in t1 while enable is high
				o_xcvr_direction <= is_wr(i_cyc_kind); // [R21] [R22]
				o_upper_mem_select_n <= ~ucs_hit; // [R16]
				o_lower_mem_select_n <= ~lcs_hit; // [R17]
				o_mid_mem_select_n <= ~mcs_vec; // [R18]
				o_periph_select_n <= ~pcs_vec[4:0]; // [R19]
				pcs_hi_n_r <= ~pcs_vec[6:5];
			end else if (st_nxt == S_T2) begin
				// reads release the address on the same edge as the read strobe falls
				o_ad <= wdata_r;
				o_ad_oe <= is_wr(kind_r); // [R7]
				o_addr_hi <= 4'h0;
			end else if (st_nxt == S_HOLD) begin
				own_r <= 1'b0; // [R14]
				o_ad_oe <= 1'b0;
			end else if (st_nxt == S_IDLE) begin
				o_ad_oe <= 1'b0;
			end
			if (st_nxt == S_IDLE || st_nxt == S_HOLD) begin
				// selects return inactive but stay driven; latched a1/a2 keep
				o_upper_mem_select_n <= 1'b1;
				o_lower_mem_select_n <= 1'b1;
				o_mid_mem_select_n <= 4'hf;
				o_periph_select_n <= 5'h1f;
				pcs_hi_n_r <= 2'h3;
			end
			o_hold_grant <= (st_nxt == S_HOLD); // [R14] [R15]
			wr_n_r <= ~(nx_data & is_wr(kind_r)); // [R3]
			rd_n_r <= ~(nx_data & is_rd(kind_r)); // [R7]
			o_xcvr_enable_n <= ~(nx_data & has_data); // [R22]
			if (st_nxt == S_T4 && st_r != S_T4) begin
				status_r <= `CLB_ST_PASV; // [R13]
				o_cyc_done <= 1'b1; // [R9]
				o_cyc_rdata <= is_rd(kind_r) ? i_ad : 16'h0000;
			end
			// lock holds from the first data cycle until the prefix is done
			if (!i_lock_req) begin
				lock_r <= 1'b0; // [R11]
			end else if (st_nxt == S_T2 && kind_r != `CLB_ST_FETCH) begin
				lock_r <= 1'b1; // [R11]
			end
		end
	end

	// ****************************************
	// pin multiplexing and floats
	// ****************************************
	wire drive_ctl = own_r | drive_pulse;
	assign o_ale_or_queue_state_lo = qmode_r ? queue_r[0] : ale_r; // [R2] [R5] [R6]
	assign o_wr_n_or_queue_state_hi = drive_pulse ? 1'b1 :
		(qmode_r ? queue_r[1] : wr_n_r); // [R3] [R4] [R5]
	assign o_wr_oe = drive_pulse | (qmode_r & i_rst_n) | own_r; // [R3] [R4]
	assign o_rd_n = drive_pulse | rd_n_r; // [R7]
	assign o_rd_oe = drive_pulse | (own_r & ~qmode_r); // [R6] [R7]
	assign o_lock_n = drive_pulse | ~lock_r; // [R11]
	assign o_lock_oe = drive_ctl; // [R11]
	assign o_cycle_status = drive_pulse ? `CLB_ST_PASV : status_r; // [R13]
	assign o_cycle_status_oe = drive_ctl;
	assign o_addr_hi_oe = own_r;
	assign o_xcvr_direction_oe = own_r; // [R14]
	assign o_xcvr_enable_oe = own_r; // [R14]
	assign o_periph_select5_or_addr1 = mode_r[`CLB_MODE_PCS_ADR] ? lat_a_r[1] :
		pcs_hi_n_r[5]; // [R20]
	assign o_periph_select6_or_addr2 = mode_r[`CLB_MODE_PCS_ADR] ? lat_a_r[2] :
		pcs_hi_n_r[6]; // [R20]

	// ****************************************
	// setup registers
	// ****************************************
	// writes to unmapped or read-only offsets are dropped
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			ucs_size_r <= `CLB_RST_UCS_SIZE;
			lcs_size_r <= `CLB_RST_LCS_SIZE;
			mcs_base_r <= `CLB_RST_MCS_BASE;
			mcs_size_r <= `CLB_RST_MCS_SIZE;
			pcs_base_r <= `CLB_RST_PCS_BASE;
			mode_r <= `CLB_RST_MODE;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`CLB_REG_UCS_SIZE: ucs_size_r <= i_reg_wdata[3:0];
				`CLB_REG_LCS_SIZE: lcs_size_r <= i_reg_wdata[3:0];
				`CLB_REG_MCS_BASE: mcs_base_r <= i_reg_wdata[6:0];
				`CLB_REG_MCS_SIZE: mcs_size_r <= i_reg_wdata[2:0];
				`CLB_REG_PCS_BASE: pcs_base_r <= i_reg_wdata[5:0];
				`CLB_REG_MODE:     mode_r <= i_reg_wdata[3:0];
				default: ;
			endcase
		end
	end

	// read value; unmapped offsets read as zero
	always @* begin
		case (i_reg_addr)
			`CLB_REG_UCS_SIZE: reg_val = {12'h000, ucs_size_r};
			`CLB_REG_LCS_SIZE: reg_val = {12'h000, lcs_size_r};
			`CLB_REG_MCS_BASE: reg_val = {9'h000, mcs_base_r};
			`CLB_REG_MCS_SIZE: reg_val = {13'h0000, mcs_size_r};
			`CLB_REG_PCS_BASE: reg_val = {10'h000, pcs_base_r};
			`CLB_REG_MODE:     reg_val = {12'h000, mode_r};
			`CLB_REG_STAT:     reg_val = {5'h00, qmode_r, o_hold_grant, lock_r, own_r, st_r};
			default:           reg_val = 16'h0000;
		endcase
	end

	// read data stand for exactly the cycle after the strobe
	always @(posedge i_clk_sys) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 16'h0000;
		end else begin
			o_reg_rdata <= i_reg_rd ? reg_val : 16'h0000;
		end
	end
endmodule // clb_bus_ctrl
`default_nettype wire

//--- clb_map.vh
`ifndef CLB_MAP_VH
`define CLB_MAP_VH
// ****************************************
// register offsets on the setup port
// ****************************************
`define CLB_REG_UCS_SIZE 3'h0
`define CLB_REG_LCS_SIZE 3'h1
`define CLB_REG_MCS_BASE 3'h2
`define CLB_REG_MCS_SIZE 3'h3
`define CLB_REG_PCS_BASE 3'h4
`define CLB_REG_MODE     3'h5
`define CLB_REG_STAT     3'h6
// ****************************************
// reset values
// ****************************************
`define CLB_RST_UCS_SIZE 4'h0
`define CLB_RST_LCS_SIZE 4'h0
`define CLB_RST_MCS_BASE 7'h00
`define CLB_RST_MCS_SIZE 3'h0
`define CLB_RST_PCS_BASE 6'h00
`define CLB_RST_MODE     4'h0
// ****************************************
// mode register bit positions
// ****************************************
`define CLB_MODE_LCS_EN  0
`define CLB_MODE_MCS_EN  1
`define CLB_MODE_PCS_EN  2
`define CLB_MODE_PCS_ADR 3
// ****************************************
// size limits (1k blocks, 8k blocks)
// ****************************************
`define CLB_KB_MAX_CODE  4'h8
`define CLB_MID_MAX_CODE 3'h6
`define CLB_MID_QSHIFT   5'h0b
// ****************************************
// cycle status codes
// ****************************************
`define CLB_ST_INTA  3'h0
`define CLB_ST_IORD  3'h1
`define CLB_ST_IOWR  3'h2
`define CLB_ST_HALT  3'h3
`define CLB_ST_FETCH 3'h4
`define CLB_ST_MEMRD 3'h5
`define CLB_ST_MEMWR 3'h6
`define CLB_ST_PASV  3'h7
// ****************************************
// queue state codes
// ****************************************
`define CLB_Q_NOP   2'h0
`define CLB_Q_FIRST 2'h1
`define CLB_Q_EMPTY 2'h2
`define CLB_Q_NEXT  2'h3
`endif

//--- clb_bus_ctrl_properties.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// bus control checker
// ****
module clb_bus_ctrl_chk (
	input wire logic       i_clk_sys,
	input wire logic       i_rst_n,
	input wire logic       i_cyc_req,
	input wire logic [2:0] i_cyc_kind,
	input wire logic [1:0] i_queue_op,
	input wire logic       i_rd_in,
	input wire logic       i_async_ready_in,
	input wire logic       i_sync_ready_in,
	input wire logic       i_hold_req,
	input wire logic       o_cyc_ready,
	input wire logic       o_cyc_done,
	input wire logic       o_ale_or_queue_state_lo,
	input wire logic       o_wr_n_or_queue_state_hi,
	input wire logic       o_wr_oe,
	input wire logic       o_rd_n,
	input wire logic       o_rd_oe,
	input wire logic       o_ad_oe,
	input wire logic       o_lock_n,
	input wire logic       o_lock_oe,
	input wire logic [2:0] o_cycle_status,
	input wire logic       o_hold_grant,
	input wire logic       o_xcvr_direction,
	input wire logic       o_xcvr_enable_n
);
	logic qm_r;
	wire  acc = i_cyc_req && o_cyc_ready;
	// own copy of the strap, the last sample taken in reset wins
	always @(posedge i_clk_sys)
		if (!i_rst_n)
			qm_r <= ~i_rd_in;
	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);
	ale_one_t1_a: assert property (acc && !qm_r |=> o_ale_or_queue_state_lo ##1
		!o_ale_or_queue_state_lo) else $error("latch strobe not confined to T1");
	status_code_a: assert property (acc |=> o_cycle_status == $past(i_cyc_kind))
		else $error("cycle status differs from kind");
	no_early_done_a: assert property (acc |=> !o_cyc_done [*3])
		else $error("cycle ended before T4");
	ready_ends_a: assert property (o_cyc_done |-> $past(i_sync_ready_in || i_async_ready_in))
		else $error("cycle ended without ready");
	wr_dir_a: assert property (!qm_r && o_wr_oe && !o_wr_n_or_queue_state_hi |->
		o_xcvr_direction) else $error("write strobe with receive direction");
	rd_float_a: assert property (o_rd_oe && !o_rd_n |-> !o_ad_oe && !o_xcvr_direction)
		else $error("read strobe while address driven");
	den_turn_a: assert property ($past(i_rst_n) && $changed(o_xcvr_direction) |->
		o_xcvr_enable_n) else $error("enable low on direction change");
	grant_float_a: assert property (o_hold_grant |-> !o_ad_oe && !o_rd_oe && !o_lock_oe)
		else $error("bus driven under grant");
	grant_drop_a: assert property (!i_hold_req [*4] |-> !o_hold_grant)
		else $error("grant kept after hold low");
	lock_fetch_a: assert property (o_lock_oe && !o_lock_n |-> !(acc && i_cyc_kind == 3'h4))
		else $error("fetch taken under lock");
	queue_pins_a: assert property (qm_r && $past(i_rst_n) |->
		{o_wr_n_or_queue_state_hi, o_ale_or_queue_state_lo} == $past(i_queue_op))
		else $error("queue pins differ");
endmodule // clb_bus_ctrl_chk
bind clb_bus_ctrl clb_bus_ctrl_chk u_chk (.*);
`default_nettype wire

//--- clb_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****
// memory and io device on the local bus
// ****
module clb_mem_model (
	input  wire logic        i_clk_sys,
	input  wire logic [15:0] i_ad,
	input  wire logic        i_ad_oe,
	input  wire logic        i_ale,
	input  wire logic        i_rd_n,
	input  wire logic        i_rd_oe,
	input  wire logic        i_wr_n,
	input  wire logic        i_wr_oe,
	input  wire logic [3:0]  i_waits,
	input  wire logic        i_use_async,
	output logic      [15:0] o_ad,
	output logic             o_sync_ready,
	output logic             o_async_ready
);
	logic [15:0] mem_r [0:15];
	logic [3:0]  idx_r;
	logic [15:0] last_r;
	logic        busy_r;
	integer      cnt_r;
	integer      i;
	wire rdy = busy_r && (cnt_r >= 1 + i_waits);
	initial begin
		for (i = 0; i < 16; i++)
			mem_r[i] = 16'h0000;
		last_r = 16'h0000;
		busy_r = 1'b0;
		cnt_r = 0;
	end
	// ready changes only at clock edges; the unused line stays low
	assign o_sync_ready = rdy && !i_use_async;
	assign o_async_ready = rdy && i_use_async;
	// a released bus shows a changing pattern, never stale data
	assign o_ad = (i_rd_oe && !i_rd_n) ? mem_r[idx_r] : ~last_r;
	always @(posedge i_clk_sys) begin
		last_r <= o_ad;
		if (i_ale && i_ad_oe) begin
			idx_r <= i_ad[4:1];
			busy_r <= 1'b1;
			cnt_r <= 0;
		end else
			cnt_r <= cnt_r + 1;
		if (i_wr_oe && !i_wr_n && i_ad_oe)
			mem_r[idx_r] <= i_ad;
	end
endmodule // clb_mem_model
`default_nettype wire

//--- clb_bus_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "clb_map.vh"
// ****
// bench top
// ****
module clb_bus_ctrl_tb;
	logic        i_clk_sys, i_rst_n, i_reg_wr, i_reg_rd, i_cyc_req, i_lock_req, i_hold_req;
	logic [2:0]  i_reg_addr, i_cyc_kind;
	logic [15:0] i_reg_wdata, i_cyc_wdata;
	logic [19:0] i_cyc_addr;
	logic [1:0]  i_queue_op;
	logic        strap_low, use_async, lock_seen, ucs_seen, exp_u, mem_k, pa;
	logic [3:0]  waits, code, mexp;
	logic [6:0]  sel;
	logic [15:0] exp_mem [0:15];
	integer      errors, checks_done, cycles, i, k;
	logic [19:0] a;
	logic [15:0] d;
	wire  [15:0] o_reg_rdata, o_cyc_rdata, o_ad, i_ad;
	wire  [3:0]  o_addr_hi, o_mid_mem_select_n;
	wire  [4:0]  o_periph_select_n;
	wire  [2:0]  o_cycle_status;
	wire         o_cyc_ready, o_cyc_done, o_ale_or_queue_state_lo, o_wr_n_or_queue_state_hi;
	wire         o_wr_oe, o_rd_n, o_rd_oe, o_ad_oe, o_addr_hi_oe, o_lock_n, o_lock_oe;
	wire         o_cycle_status_oe, o_hold_grant, o_upper_mem_select_n, o_lower_mem_select_n;
	wire         o_periph_select5_or_addr1, o_periph_select6_or_addr2, o_xcvr_direction;
	wire         o_xcvr_direction_oe, o_xcvr_enable_n, o_xcvr_enable_oe;
	wire         i_async_ready_in, i_sync_ready_in;
	// board ties the read pin low for queue mode, else a weak pull-up
	wire         i_rd_in = strap_low ? 1'b0 : (o_rd_oe ? o_rd_n : 1'b1);
	clb_bus_ctrl dut (.*);
	clb_mem_model u_mem (.i_clk_sys(i_clk_sys), .i_ad(o_ad), .i_ad_oe(o_ad_oe),
		.i_ale(o_ale_or_queue_state_lo), .i_rd_n(o_rd_n), .i_rd_oe(o_rd_oe),
		.i_wr_n(o_wr_n_or_queue_state_hi), .i_wr_oe(o_wr_oe), .i_waits(waits),
		.i_use_async(use_async), .o_ad(i_ad), .o_sync_ready(i_sync_ready_in),
		.o_async_ready(i_async_ready_in));
	initial begin
		i_clk_sys = 1'b0;
		forever #10 i_clk_sys = ~i_clk_sys;
	end
	// sticky monitors and the hang limit
	always @(posedge i_clk_sys) begin
		cycles = cycles + 1;
		if (o_lock_oe && !o_lock_n) lock_seen <= 1'b1;
		if (!o_upper_mem_select_n) ucs_seen <= 1'b1;
		if (cycles > 20000) begin
			errors = errors + 1;
			finish_test;
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done = checks_done + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task do_reset(input logic s);
		@(posedge i_clk_sys);
		i_rst_n <= 1'b0;
		strap_low <= s;
		repeat (12) @(posedge i_clk_sys);
		i_rst_n <= 1'b1;
	endtask
	task reg_wr(input logic [2:0] ad, input logic [15:0] wd);
		@(posedge i_clk_sys);
		i_reg_addr <= ad;
		i_reg_wdata <= wd;
		i_reg_wr <= 1'b1;
		@(posedge i_clk_sys);
		i_reg_wr <= 1'b0;
	endtask
	task reg_rd(input logic [2:0] ad, input logic [15:0] e);
		@(posedge i_clk_sys);
		i_reg_addr <= ad;
		i_reg_rd <= 1'b1;
		@(posedge i_clk_sys);
		i_reg_rd <= 1'b0;
		@(negedge i_clk_sys);
		chk(o_reg_rdata, e);
	endtask
	// one core cycle: wait for acceptance, then follow it to done
	task cyc(input logic [2:0] kd, input logic [19:0] ad, input logic [15:0] wd);
		integer n;
		@(posedge i_clk_sys);
		i_cyc_kind <= kd;
		i_cyc_addr <= ad;
		i_cyc_wdata <= wd;
		i_cyc_req <= 1'b1;
		n = 0;
		@(negedge i_clk_sys);
		while (o_cyc_ready !== 1'b1 && n < 50) begin
			n = n + 1;
			@(negedge i_clk_sys);
		end
		@(posedge i_clk_sys);
		i_cyc_req <= 1'b0;
		@(negedge i_clk_sys);
		lock_seen = 1'b0;
		ucs_seen = 1'b0;
		chk(o_cycle_status, kd);
		chk(o_ale_or_queue_state_lo, 1);
		// selects are set on the accept edge, so they stand here in t1
		mem_k = (kd == `CLB_ST_FETCH || kd == `CLB_ST_MEMRD || kd == `CLB_ST_MEMWR);
		chk(o_lower_mem_select_n, !(mem_k && ad < 20'h00400));
		mexp = (mem_k && ad < 20'h02000) ? ~(4'h1 << ad[12:11]) : 4'hf;
		chk(o_mid_mem_select_n, mexp);
		sel = ((kd == `CLB_ST_IORD || kd == `CLB_ST_IOWR) && ad[15:10] == 6'h00) ?
			~(7'h01 << ad[9:7]) : 7'h7f;
		if (pa) sel[6:5] = ad[2:1];
		chk({o_periph_select6_or_addr2, o_periph_select5_or_addr1, o_periph_select_n}, sel);
		n = 1;
		while (o_cyc_done !== 1'b1 && n < 60) begin
			n = n + 1;
			@(negedge i_clk_sys);
		end
		if (!use_async) chk(n, 4 + waits);
		if (kd == `CLB_ST_IORD || kd == `CLB_ST_MEMRD || kd == `CLB_ST_FETCH)
			chk(o_cyc_rdata, exp_mem[ad[4:1]]);
		if (kd == `CLB_ST_IOWR || kd == `CLB_ST_MEMWR)
			exp_mem[ad[4:1]] = wd;
		exp_u = (kd == `CLB_ST_FETCH || kd == `CLB_ST_MEMRD || kd == `CLB_ST_MEMWR)
			&& ({12'h000, ad} >= 32'h100000 - (32'h400 << code));
		chk(ucs_seen, exp_u);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	initial begin
		{i_reg_wr, i_reg_rd, i_cyc_req, i_lock_req, i_hold_req, strap_low, use_async} = 7'h00;
		{i_reg_addr, i_cyc_kind, i_queue_op, waits} = 12'h000;
		{i_reg_wdata, i_cyc_wdata, i_cyc_addr} = 52'h0;
		i_rst_n = 1'b0;
		errors = 0;
		checks_done = 0;
		cycles = 0;
		pa = 1'b0;
		for (i = 0; i < 16; i++)
			exp_mem[i] = 16'h0000;
		void'($urandom(32'h0768));
		do_reset(1'b0);
		code = $urandom % 9;
		reg_wr(`CLB_REG_UCS_SIZE, {12'h000, code});
		reg_rd(`CLB_REG_UCS_SIZE, {12'h000, code});
		reg_rd(3'h7, 16'h0000);
		reg_rd(`CLB_REG_STAT, 16'h0001);
		reg_wr(`CLB_REG_MODE, 16'h0007);
		reg_rd(`CLB_REG_MODE, 16'h0007);
		$display("test registers done");
		// every cycle kind except passive, with waits and both ready inputs
		for (k = 0; k < 21; k++) begin
			waits <= $urandom % 4;
			use_async <= $urandom % 2;
			a = ($urandom % 2) ? 20'hfffff - ($urandom % (32'h800 << code)) : $urandom;
			d = $urandom;
			cyc(k % 7, a, d);
		end
		// decoded selects on fixed addresses: pcs6, pcs3 and mid quarter 3
		cyc(`CLB_ST_IOWR, 20'h00300, 16'h1234);
		cyc(`CLB_ST_IORD, 20'h00180, 16'h0000);
		cyc(`CLB_ST_MEMRD, 20'h01810, 16'h0000);
		$display("test cycle kinds done");
		@(posedge i_clk_sys);
		i_lock_req <= 1'b1;
		cyc(`CLB_ST_MEMWR, 20'h00010, 16'h5a5a);
		chk(lock_seen, 1);
		@(posedge i_clk_sys);
		i_lock_req <= 1'b0;
		repeat (2) @(posedge i_clk_sys);
		cyc(`CLB_ST_MEMRD, 20'h00010, 16'h0000);
		chk(lock_seen, 0);
		$display("test lock done");
		@(posedge i_clk_sys);
		i_hold_req <= 1'b1;
		k = 0;
		while (o_hold_grant !== 1'b1 && k < 10) begin
			k = k + 1;
			@(negedge i_clk_sys);
		end
		chk({o_hold_grant, o_ad_oe, o_rd_oe}, 3'h4);
		@(posedge i_clk_sys);
		i_hold_req <= 1'b0;
		k = 0;
		while (o_hold_grant !== 1'b0 && k < 10) begin
			k = k + 1;
			@(negedge i_clk_sys);
		end
		chk(o_hold_grant, 0);
		cyc(`CLB_ST_MEMRD, 20'h00010, 16'h0000);
		// pins 5 and 6 switched to latched a1/a2; they still show them in t4, when done is seen
		pa = 1'b1;
		reg_wr(`CLB_REG_MODE, 16'h000f);
		cyc(`CLB_ST_MEMRD, 20'h00004, 16'h0000);
		chk({o_periph_select6_or_addr2, o_periph_select5_or_addr1}, 2'h2);
		$display("test hold done");
		do_reset(1'b1);
		for (k = 0; k < 4; k++) begin
			@(posedge i_clk_sys);
			i_queue_op <= k;
			@(posedge i_clk_sys);
			@(negedge i_clk_sys);
			chk({o_wr_n_or_queue_state_hi, o_ale_or_queue_state_lo}, k);
		end
		$display("test queue mode done");
		finish_test;
	end
endmodule // clb_bus_ctrl_tb
`default_nettype wire
